// ---- bench/safe_torque_off_sequencer_tb.sv ----
// Purpose: self-checking bench of the safe torque-off sequencer
// Assumes: timing tick shortened to TD clock cycles
// Notes:   inputs change 1 ns after the rising edge
module safe_torque_off_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TD = 10;
	logic        clk, nrst, trig, ose, ena, hold_off, supply;
	logic        fb_open, brake, stage, sto, fault;
	logic [15:0] cmd, acc, qstep, sdly, rtime, ddly, speed;
	logic [6:0]  seg;
	int          bad_count = 0;
	int          n_checks = 0;

	sto_sequencer #(.TICK_DIV(TD)) u_sto_sequencer (.clk(clk), .nrst(nrst), .relay_trigger_input(trig),
		.output_stage_enable_input(ose), .controller_enable_input(ena), .driver_supply_present(supply),
		.commanded_speed(cmd), .accel_step(acc), .quick_stop_step(qstep), .start_delay_ticks(sdly),
		.ramp_time_ticks(rtime), .dropout_delay_ticks(ddly), .feedback_contact_open(fb_open),
		.brake_release(brake), .stage_enable(stage), .speed_setpoint(speed), .segment_out(seg),
		.sto_active(sto), .pulse_inhibit_fault(fault));
	supply_model u_supply_model (.clk(clk), .nrst(nrst), .relay_trigger(trig), .hold_off(hold_off),
		.supply_present(supply));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic logic pick(input int k);
		case (k)
			0: return fb_open;
			1: return sto;
			2: return stage;
			3: return speed == cmd;
			4: return speed == 16'h0000;
			default: return seg == 7'h00;
		endcase
	endfunction
	task automatic wait_for(input int k, input logic v, input int lim, output int n);
		n = 0;
		while (pick(k) !== v && n <= lim) begin
			step(1);
			n++;
		end
	endtask
	task automatic in_range(input string what, input int n, input int lo, input int hi);
		check(what, 16'((n >= lo) && (n <= hi)), 16'h0001);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		int n;
		check("contact", 16'(fb_open), 16'h0000);
		check("brake", 16'(brake), 16'h0000);
		check("stage", 16'(stage), 16'h0000);
		check("sto", 16'(sto), 16'h0001);
		check("segment", 16'(seg), 16'h0076);
		wait_for(5, 1'b1, 260 * TD, n);
		in_range("blink half", n, 249 * TD, 251 * TD + 4);
		$display("test reset done");
	endtask
	task automatic t_start;
		int n;
		trig = 1'b1;
		wait_for(0, 1'b1, 30 * TD, n);
		in_range("contact open time", n, 1, 20 * TD + 4);
		wait_for(1, 1'b0, 15 * TD, n);
		in_range("indication off time", n, 9 * TD, 11 * TD + 4);
		check("segment blank", 16'(seg), 16'h0000);
		check("no fault", 16'(fault), 16'h0000);
		check("supply cross-check", 16'(fb_open == supply), 16'h0001);
		$display("test start done");
	endtask
	task automatic t_run;
		int n;
		ena = 1'b1;
		step(10);
		check("refused stage", 16'(stage), 16'h0000);
		ena = 1'b0;
		ose = 1'b1;
		step(1000);
		ena = 1'b1;
		wait_for(2, 1'b1, 10, n);
		in_range("stage on delay", n, 2, 4);
		check("brake released", 16'(brake), 16'h0001);
		step(4 * TD);
		check("zero speed hold", speed, 16'h0000);
		wait_for(3, 1'b1, 20 * TD, n);
		in_range("ramp up", n, 8 * TD, 13 * TD);
		$display("test run done");
	endtask
	task automatic t_stop(input logic [15:0] stp);
		int n;
		qstep = stp;
		ena = 1'b0;
		if (stp == 16'd20) begin
			wait_for(4, 1'b1, 8 * TD, n);
			in_range("decel time", n, 4 * TD, 6 * TD + 4);
			check("hold at zero", 16'(stage), 16'h0001);
			wait_for(2, 1'b0, 5 * TD, n);
			in_range("dropout time", n, 2 * TD, 4 * TD + 4);
		end else begin
			wait_for(2, 1'b0, 13 * TD, n);
			in_range("forced brake", n, 10 * TD, 12 * TD + 4);
			check("still moving", 16'(speed != 16'h0000), 16'h0001);
		end
		check("brake applied", 16'(brake), 16'h0000);
		$display("test stop done");
	endtask
	task automatic t_sto;
		int n;
		trig = 1'b0;
		ose = 1'b0;
		ena = 1'b0;
		step(4);
		check("coast stage", 16'(stage), 16'h0000);
		check("coast brake", 16'(brake), 16'h0000);
		wait_for(0, 1'b0, 90 * TD, n);
		in_range("contact close", n, 78 * TD, 81 * TD + 4);
		wait_for(1, 1'b1, 40 * TD, n);
		in_range("indication back", n, 30 * TD, 32 * TD + 4);
		check("segment H", 16'(seg), 16'h0076);
		$display("test torque-off done");
	endtask
	task automatic t_fault;
		hold_off = 1'b1;
		nrst = 1'b0;
		step(2);
		nrst = 1'b1;
		step(2);
		trig = 1'b1;
		step(30 * TD);
		check("mismatch fault", 16'(fault), 16'h0001);
		check("contact closed", 16'(fb_open), 16'h0000);
		$display("test fault done");
	endtask

	// ----------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#500000;
		bad_count++;
		end_of_test();
	end
	initial begin
		nrst = 1'b0;
		{trig, ose, ena, hold_off} = 4'h0;
		cmd = 16'd100;
		acc = 16'd10;
		qstep = 16'd20;
		sdly = 16'd5;
		rtime = 16'd8;
		ddly = 16'd3;
		step(5);
		nrst = 1'b1;
		step(2);
		t_reset();
		t_start();
		t_run();
		t_stop(16'd20);
		t_sto();
		t_start();
		t_run();
		t_sto();
		t_start();
		t_run();
		t_stop(16'd1);
		t_fault();
		end_of_test();
	end
endmodule

// ---- bench/supply_model.sv ----
// Purpose: driver supply behind the relay, as seen by the sequencer
// Assumes: supply follows the relay trigger after fixed charge and drain times
// Notes:   hold_off models a relay that never closes
module supply_model #(
	parameter int CHARGE_CYC = 50,
	parameter int DRAIN_CYC  = 50
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic relay_trigger,
	input  wire logic hold_off,
	output logic      supply_present
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;

	// ----------------------------------------
	// charge and drain timing
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt            <= 0;
			supply_present <= 1'b0;
		end else if (relay_trigger && !hold_off && !supply_present) begin
			cnt <= cnt + 1;
			if (cnt >= CHARGE_CYC) begin
				supply_present <= 1'b1;
				cnt            <= 0;
			end
		end else if (!relay_trigger && supply_present) begin
			cnt <= cnt + 1;
			if (cnt >= DRAIN_CYC) begin
				supply_present <= 1'b0;
				cnt            <= 0;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule

// ---- shared/sto_seq_params.svh ----
// Purpose: timing and encoding constants of the safe torque-off sequencer
// Assumes: 100 MHz clock, 1 ms timing tick
// Notes:   times in ms are derived to tick counts below
`ifndef STO_SEQ_PARAMS_SVH
`define STO_SEQ_PARAMS_SVH
`define CLK_PERIOD_NS        10
`define TICK_PERIOD_NS       1000000
`define TICK_DIV             (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define FEEDBACK_OPEN_MS     20
`define INDICATION_OFF_MS    10
`define FEEDBACK_CLOSE_MS    80
`define INDICATION_ON_MS     30
`define BLINK_HALF_MS        250
`define SEG_LETTER_H         7'h76
`define SEG_BLANK            7'h00
`endif

// ---- shared/sto_seq_pkg.sv ----
// Purpose: types of the safe torque-off sequencer
// Assumes: nothing
// Notes:   none
package sto_seq_pkg;
	typedef enum logic [2:0] {
		MOT_HALT,
		MOT_HOLD,
		MOT_ACCEL,
		MOT_RUN,
		MOT_DECEL,
		MOT_DROPOUT
	} motion_state_t;
	typedef enum logic [1:0] {
		SUP_OFF,
		SUP_CHARGING,
		SUP_ON,
		SUP_DISCHARGING
	} supply_state_t;
endpackage

// ---- verilog/input_sync.sv ----
// Purpose: two-stage synchroniser for a group of level inputs
// Assumes: inputs are levels
// Notes:   first stage is read only by the second
module input_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_sync;

	always_comb begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ---- verilog/sto_sequencer.sv ----
// Purpose: safe torque-off sequencer of a servo drive
// Assumes: driver supply charge/discharge modelled by tick timers
// Notes:   all delays counted in ticks of TICK_DIV clock cycles
`include "sto_seq_params.svh"

// Notes on behaviour
// - flashing H shown while torque-off
// - feedback contact opens within 20ms
// - indication removed about 10ms later
// - enable rise releases brake, enables stage
// - brake release needs relay trigger
// - hold zero speed for start delay
// - ramp up to commanded speed
// - enable fall starts quick-stop ramp
// - hold zero for drop-out, then brake
// - drop-out end removes stage enable
// - brake at latest after ramp plus drop-out
// - feedback closes 80ms after trigger loss
// - indication back 31ms after contact closes
// - torque-off while running coasts, brakes
// - bus stays charged, resumes at once
// - flag trigger versus supply mismatch fault
// - contact normally closed, open with supply
module sto_sequencer
	import sto_seq_pkg::*;
#(
	parameter int TICK_DIV = `TICK_DIV,
	parameter int SPEED_W  = 16,
	parameter int TIME_W   = 16
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               relay_trigger_input,
	input  wire logic               output_stage_enable_input,
	input  wire logic               controller_enable_input,
	input  wire logic               driver_supply_present,
	input  wire logic [SPEED_W-1:0] commanded_speed,
	input  wire logic [SPEED_W-1:0] accel_step,
	input  wire logic [SPEED_W-1:0] quick_stop_step,
	input  wire logic [TIME_W-1:0]  start_delay_ticks,
	input  wire logic [TIME_W-1:0]  ramp_time_ticks,
	input  wire logic [TIME_W-1:0]  dropout_delay_ticks,
	output logic                    feedback_contact_open,
	output logic                    brake_release,
	output logic                    stage_enable,
	output logic [SPEED_W-1:0]      speed_setpoint,
	output logic [6:0]              segment_out,
	output logic                    sto_active,
	output logic                    pulse_inhibit_fault
);
	import sto_seq_pkg::*;

	// ----------------------------------------
	// input synchronisation and tick
	// ----------------------------------------
	logic [2:0] sync_in;
	logic       tick;
	logic       trig_s;
	logic       ose_s;
	logic       cen_s;

	input_sync #(.WIDTH(3)) u_sync (
		.clk      (clk),
		.nrst     (nrst),
		.async_in ({relay_trigger_input, output_stage_enable_input, controller_enable_input}),
		.sync_out (sync_in)
	);

	tick_gen #(.DIV(TICK_DIV)) u_tick (
		.clk  (clk),
		.nrst (nrst),
		.tick (tick)
	);

	assign trig_s = sync_in[2];
	assign ose_s  = sync_in[1];
	assign cen_s  = sync_in[0];

	// ----------------------------------------
	// driver supply, feedback contact and indication
	// ----------------------------------------
	supply_state_t sup_ff;
	supply_state_t nxt_sup;
	logic [7:0]    sup_cnt_ff;
	logic [7:0]    nxt_sup_cnt;
	logic          ind_ff;
	logic          nxt_ind;
	logic [7:0]    ind_cnt_ff;
	logic [7:0]    nxt_ind_cnt;
	logic [8:0]    blink_cnt_ff;
	logic [8:0]    nxt_blink_cnt;
	logic          blink_ff;
	logic          nxt_blink;
	logic          fault_ff;
	logic          nxt_fault;

	always_comb begin
		nxt_sup     = sup_ff;
		nxt_sup_cnt = sup_cnt_ff;
		case (sup_ff)
			SUP_OFF: begin
				if (trig_s) begin
					nxt_sup     = SUP_CHARGING;
					nxt_sup_cnt = 8'h0;
				end
			end
			SUP_CHARGING: begin
				if (!trig_s) begin
					nxt_sup = SUP_OFF;
				end else if (sup_cnt_ff >= 8'(`FEEDBACK_OPEN_MS - 1) && driver_supply_present) begin
					nxt_sup = SUP_ON;
				end else if (tick && sup_cnt_ff < 8'(`FEEDBACK_OPEN_MS - 1)) begin
					nxt_sup_cnt = sup_cnt_ff + 8'h1;
				end
			end
			SUP_ON: begin
				if (!trig_s) begin
					nxt_sup     = SUP_DISCHARGING;
					nxt_sup_cnt = 8'h0;
				end
			end
			SUP_DISCHARGING: begin
				if (trig_s) begin
					nxt_sup = SUP_ON;
				end else if (tick) begin
					nxt_sup_cnt = sup_cnt_ff + 8'h1;
					if (sup_cnt_ff + 8'h1 >= 8'(`FEEDBACK_CLOSE_MS)) begin
						nxt_sup = SUP_OFF;
					end
				end
			end
			default: nxt_sup = SUP_OFF;
		endcase
	end

	// indication: off 10 ticks after contact opens, on 31 ticks after it closes
	always_comb begin
		nxt_ind     = ind_ff;
		nxt_ind_cnt = ind_cnt_ff;
		if (feedback_contact_open == ind_ff) begin
			if (tick) begin
				nxt_ind_cnt = ind_cnt_ff + 8'h1;
			end
			if (feedback_contact_open && ind_cnt_ff >= 8'(`INDICATION_OFF_MS)) begin
				nxt_ind     = 1'b0;
				nxt_ind_cnt = 8'h0;
			end else if (!feedback_contact_open && ind_cnt_ff > 8'(`INDICATION_ON_MS)) begin
				nxt_ind     = 1'b1;
				nxt_ind_cnt = 8'h0;
			end
		end else begin
			nxt_ind_cnt = 8'h0;
		end
		nxt_blink     = blink_ff || !ind_ff;
		nxt_blink_cnt = ind_ff ? blink_cnt_ff : 9'h0;
		if (tick && ind_ff) begin
			nxt_blink_cnt = blink_cnt_ff + 9'h1;
			if (blink_cnt_ff >= 9'(`BLINK_HALF_MS - 1)) begin
				nxt_blink_cnt = 9'h0;
				nxt_blink     = !blink_ff;
			end
		end
		// trigger and monitored supply disagree outside the charging and discharge times
		nxt_fault = fault_ff | ((sup_ff == SUP_ON) && !driver_supply_present)
			| ((sup_ff == SUP_CHARGING) && (sup_cnt_ff >= 8'(`FEEDBACK_OPEN_MS - 1)) && !driver_supply_present)
			| ((sup_ff == SUP_OFF) && !trig_s && driver_supply_present);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sup_ff       <= SUP_OFF;
			sup_cnt_ff   <= 8'h0;
			ind_ff       <= 1'b1;
			ind_cnt_ff   <= 8'h0;
			blink_cnt_ff <= 9'h0;
			blink_ff     <= 1'b1;
			fault_ff     <= 1'b0;
		end else begin
			sup_ff       <= nxt_sup;
			sup_cnt_ff   <= nxt_sup_cnt;
			ind_ff       <= nxt_ind;
			ind_cnt_ff   <= nxt_ind_cnt;
			blink_cnt_ff <= nxt_blink_cnt;
			blink_ff     <= nxt_blink;
			fault_ff     <= nxt_fault;
		end
	end

	// normally closed: open only while supply is up
	assign feedback_contact_open = (sup_ff == SUP_ON) || (sup_ff == SUP_DISCHARGING);
	assign sto_active            = ind_ff;
	assign segment_out           = (ind_ff && blink_ff) ? `SEG_LETTER_H : `SEG_BLANK;
	assign pulse_inhibit_fault   = fault_ff;

	// ----------------------------------------
	// motion sequence
	// ----------------------------------------
	motion_state_t       mot_ff;
	motion_state_t       nxt_mot;
	logic [TIME_W-1:0]   tmr_ff;
	logic [TIME_W-1:0]   nxt_tmr;
	logic [SPEED_W-1:0]  spd_ff;
	logic [SPEED_W-1:0]  nxt_spd;
	logic                cen_d_ff;
	logic                safe_ok;
	logic [TIME_W:0]     stop_budget;

	assign safe_ok     = trig_s && ose_s;
	assign stop_budget = {1'b0, ramp_time_ticks} + {1'b0, dropout_delay_ticks};

	always_comb begin
		nxt_mot = mot_ff;
		nxt_tmr = tmr_ff;
		nxt_spd = spd_ff;
		case (mot_ff)
			MOT_HALT: begin
				nxt_spd = '0;
				// bus stays charged, so restart is immediate
				if (safe_ok && cen_s && !cen_d_ff) begin
					nxt_mot = MOT_HOLD;
					nxt_tmr = '0;
				end
			end
			MOT_HOLD: begin
				nxt_spd = '0;
				if (tick) begin
					nxt_tmr = tmr_ff + 1'b1;
				end
				if (tmr_ff >= start_delay_ticks) begin
					nxt_mot = MOT_ACCEL;
				end
			end
			MOT_ACCEL: begin
				if (commanded_speed - spd_ff <= accel_step) begin
					nxt_spd = commanded_speed;
					nxt_mot = MOT_RUN;
				end else if (tick) begin
					nxt_spd = spd_ff + accel_step;
				end
			end
			MOT_RUN: begin
				nxt_spd = commanded_speed;
			end
			MOT_DECEL: begin
				if (tick) begin
					nxt_tmr = tmr_ff + 1'b1;
					nxt_spd = (spd_ff <= quick_stop_step) ? '0 : spd_ff - quick_stop_step;
				end
				// dwell is the drop-out delay, but never past ramp plus drop-out
				if (spd_ff == '0) begin
					nxt_mot = MOT_DROPOUT;
					nxt_tmr = (nxt_tmr < ramp_time_ticks) ? ramp_time_ticks : nxt_tmr;
				end else if ({1'b0, tmr_ff} >= stop_budget) begin
					nxt_mot = MOT_HALT;
				end
			end
			MOT_DROPOUT: begin
				nxt_spd = '0;
				if (tick) begin
					nxt_tmr = tmr_ff + 1'b1;
				end
				if ({1'b0, tmr_ff} >= stop_budget) begin
					nxt_mot = MOT_HALT;
				end
			end
			default: nxt_mot = MOT_HALT;
		endcase
		if (mot_ff != MOT_HALT && mot_ff != MOT_DECEL && mot_ff != MOT_DROPOUT && !cen_s) begin
			nxt_mot = MOT_DECEL;
			nxt_tmr = '0;
		end
		// safety path lost: coast with brake applied
		if (!safe_ok) begin
			nxt_mot = MOT_HALT;
			nxt_spd = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mot_ff   <= MOT_HALT;
			tmr_ff   <= '0;
			spd_ff   <= '0;
			cen_d_ff <= 1'b0;
		end else begin
			mot_ff   <= nxt_mot;
			tmr_ff   <= nxt_tmr;
			spd_ff   <= nxt_spd;
			cen_d_ff <= cen_s;
		end
	end

	assign stage_enable   = (mot_ff != MOT_HALT) && safe_ok;
	assign brake_release  = (mot_ff != MOT_HALT) && trig_s;
	assign speed_setpoint = spd_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	brake_needs_trig_a: assert property (@(posedge clk) disable iff (!nrst) brake_release |-> trig_s)
		else $error("brake released without relay trigger");
	start_on_edge_a: assert property (@(posedge clk) disable iff (!nrst)
		(mot_ff == MOT_HALT && safe_ok && cen_s && !cen_d_ff) |=> stage_enable || !safe_ok)
		else $error("stage not enabled after enable edge");
	coast_on_loss_a: assert property (@(posedge clk) disable iff (!nrst)
		!safe_ok |=> mot_ff == MOT_HALT && spd_ff == '0)
		else $error("motion continues without safety signals");
	contact_closed_off_a: assert property (@(posedge clk) disable iff (!nrst)
		sup_ff == SUP_OFF |-> !feedback_contact_open)
		else $error("contact open without supply");
	hold_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		mot_ff == MOT_HOLD |-> spd_ff == '0)
		else $error("speed nonzero during start delay");
	decel_on_fall_a: assert property (@(posedge clk) disable iff (!nrst)
		(mot_ff == MOT_RUN && $fell(cen_s) && safe_ok) |=> mot_ff == MOT_DECEL)
		else $error("no quick stop on enable fall");
	ind_off_open_a: assert property (@(posedge clk) disable iff (!nrst)
		($rose(feedback_contact_open) && ind_ff) |-> ind_ff [*8])
		else $error("indication dropped at contact opening");
	ind_back_late_a: assert property (@(posedge clk) disable iff (!nrst)
		($fell(feedback_contact_open) && !ind_ff) |-> !ind_ff [*8])
		else $error("indication back too soon after contact closed");
	segment_h_a: assert property (@(posedge clk) disable iff (!nrst)
		!ind_ff |-> segment_out == `SEG_BLANK)
		else $error("letter shown outside torque-off");
	fault_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
		pulse_inhibit_fault |=> pulse_inhibit_fault)
		else $error("fault flag cleared");
endmodule

// ---- verilog/tick_gen.sv ----
// Purpose: divides the clock into a one-cycle timing tick
// Assumes: DIV of at least 1
// Notes:   tick is a pulse every DIV cycles
module tick_gen #(
	parameter int DIV = 100000
) (
	input  wire logic clk,
	input  wire logic nrst,
	output logic      tick
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic        tick_ff;
	logic        nxt_tick;

	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt  = cnt_ff + 32'h1;
		if (cnt_ff >= 32'(DIV - 1)) begin
			nxt_cnt  = 32'h0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff  <= 32'h0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule
